// ===== trk_pkg.sv
// Package for the track 2 stripe reader: register map, codes, state record.
package trk_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam int TRK_ADDR_W = 8;
    localparam logic [7:0] TRK_REG_CTRL = 8'h00;
    localparam logic [7:0] TRK_REG_STATUS = 8'h04;
    localparam logic [7:0] TRK_REG_RESULT = 8'h08;
    localparam logic [7:0] TRK_REG_BUF_BASE = 8'h40;
    localparam logic [7:0] TRK_REG_BUF_LAST = 8'h8C;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int TRK_CTRL_START = 0;
    localparam int TRK_CTRL_EDGE_RISE = 1;
    localparam int TRK_CTRL_INVERT = 2;
    localparam int TRK_CTRL_ABORT_EN = 3;
    localparam int TRK_CTRL_ABORT_SEL_LO = 4;
    localparam int TRK_CTRL_ABORT_SEL_HI = 6;

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int TRK_STAT_BUSY = 0;
    localparam int TRK_STAT_DONE = 1;
    localparam int TRK_STAT_ERROR = 2;
    localparam int TRK_STAT_FRAMED = 3;
    localparam int TRK_STAT_PARITY = 4;
    localparam int TRK_STAT_LRC = 5;
    localparam int TRK_STAT_OVERFLOW = 6;
    localparam int TRK_STAT_ABORT = 7;
    localparam int TRK_STAT_COUNT_LO = 8;
    localparam int TRK_STAT_COUNT_HI = 13;

    // ----------------------------------------------------------------
    // Character format and limits
    // ----------------------------------------------------------------
    localparam int TRK_CHAR_BITS = 5;
    localparam logic [2:0] TRK_LAST_BIT = 3'h4;
    localparam logic [3:0] TRK_START_CODE = 4'hB;
    localparam logic [3:0] TRK_END_CODE = 4'hF;
    localparam int TRK_MAX_CHARS = 40;
    localparam logic [5:0] TRK_MAX_COUNT = 6'h28;
    localparam int TRK_BUF_BYTES = 20;
    localparam logic [7:0] TRK_RESULT_ERR = 8'hFF;
    localparam int TRK_NUM_ABORT = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRK_IDLE,
        TRK_HUNT,
        TRK_CHAR,
        TRK_LRC
    } trk_phase_t;

    typedef struct packed {
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
        logic data_meta;
        logic data_sync;
        logic [7:0] abort_meta;
        logic [7:0] abort_sync;
        logic edge_rise;
        logic invert;
        logic abort_en;
        logic [2:0] abort_sel;
        trk_phase_t phase;
        logic busy;
        logic done;
        logic err;
        logic framed;
        logic err_parity;
        logic err_lrc;
        logic err_overflow;
        logic err_abort;
        logic [4:0] shreg;
        logic [2:0] bitcnt;
        logic [5:0] count;
        logic [3:0] lrc;
        logic [TRK_MAX_CHARS-1:0][3:0] nib;
        logic [31:0] rdata;
    } trk_state_t;

    localparam trk_state_t TRK_STATE_RST = '0;

endpackage : trk_pkg

// ===== trk_reader.sv
// Track 2 stripe reader: strobe/data sampling, framing, checks, nibble buffer.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module trk_reader
    import trk_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [TRK_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic strobe_in,
    input wire logic data_in,
    input wire logic [TRK_NUM_ABORT-1:0] gpin_in,
    output logic busy_out,
    output logic done_out,
    output logic error_out
);

    trk_state_t r;
    trk_state_t next_r;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic in_buffer(input logic [TRK_ADDR_W-1:0] a);
        in_buffer = (a >= TRK_REG_BUF_BASE) && (a <= TRK_REG_BUF_LAST) && (a[1:0] == 2'h0);
    endfunction : in_buffer

    function automatic logic [7:0] buffer_byte(
        input logic [TRK_MAX_CHARS-1:0][3:0] nib,
        input logic [TRK_ADDR_W-1:0] a
    );
        logic [TRK_ADDR_W-1:0] off;
        logic [5:0] k;
        off = a - TRK_REG_BUF_BASE;
        k = {off[6:2], 1'b0};
        buffer_byte = {nib[k], nib[k + 6'h01]};
    endfunction : buffer_byte

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic edge_hit;
    logic bit_in;
    logic [4:0] chr;
    logic parity_ok;
    logic aborting;

    always_comb begin
        next_r = r;
        // Two flops on every card and abort pin before any logic looks at it
        next_r.strobe_meta = strobe_in;
        next_r.strobe_sync = r.strobe_meta;
        next_r.strobe_prev = r.strobe_sync;
        next_r.data_meta = data_in;
        next_r.data_sync = r.data_meta;
        next_r.abort_meta = gpin_in;
        next_r.abort_sync = r.abort_meta;
        next_r.rdata = 32'h0000_0000;

        // Data flops share the strobe latency, so data_sync is the bit as it stood
        // at the edge; the card holds it through the whole active strobe phase.
        edge_hit = r.edge_rise ? (r.strobe_sync & ~r.strobe_prev)
                               : (~r.strobe_sync & r.strobe_prev);
        bit_in = r.data_sync ^ r.invert;
        chr = {bit_in, r.shreg[4:1]};
        parity_ok = ^chr;
        aborting = r.abort_en & r.abort_sync[r.abort_sel];

        if (r.phase != TRK_IDLE && aborting) begin
            // Checked every cycle while waiting, so a stalled card cannot hang us
            next_r.phase = TRK_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.err = 1'b1;
            next_r.err_abort = 1'b1;
        end else if (edge_hit) begin
            case (r.phase)
                TRK_IDLE: begin
                end
                TRK_HUNT: begin
                    // Sliding window: zeros and noise ahead of the sentinel just pass
                    next_r.shreg = chr;
                    if (chr[3:0] == TRK_START_CODE && parity_ok) begin
                        next_r.nib[0] = chr[3:0];
                        next_r.count = 6'h01;
                        next_r.lrc = chr[3:0];
                        next_r.bitcnt = 3'h0;
                        next_r.framed = 1'b1;
                        next_r.phase = TRK_CHAR;
                    end
                end
                TRK_CHAR: begin
                    next_r.shreg = chr;
                    next_r.bitcnt = r.bitcnt + 3'h1;
                    if (r.bitcnt == TRK_LAST_BIT) begin
                        next_r.bitcnt = 3'h0;
                        if (!parity_ok) begin
                            next_r.phase = TRK_IDLE;
                            next_r.busy = 1'b0;
                            next_r.done = 1'b1;
                            next_r.err = 1'b1;
                            next_r.err_parity = 1'b1;
                        end else if (r.count == TRK_MAX_COUNT) begin
                            next_r.phase = TRK_IDLE;
                            next_r.busy = 1'b0;
                            next_r.done = 1'b1;
                            next_r.err = 1'b1;
                            next_r.err_overflow = 1'b1;
                        end else begin
                            next_r.nib[r.count] = chr[3:0];
                            next_r.count = r.count + 6'h01;
                            next_r.lrc = r.lrc ^ chr[3:0];
                            if (chr[3:0] == TRK_END_CODE) begin
                                next_r.phase = TRK_LRC;
                            end
                        end
                    end
                end
                TRK_LRC: begin
                    // Redundancy nibble is compared only, never written to the buffer
                    next_r.shreg = chr;
                    next_r.bitcnt = r.bitcnt + 3'h1;
                    if (r.bitcnt == TRK_LAST_BIT) begin
                        next_r.bitcnt = 3'h0;
                        next_r.phase = TRK_IDLE;
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                        next_r.err_parity = ~parity_ok;
                        next_r.err_lrc = (chr[3:0] != r.lrc);
                        next_r.err = ~parity_ok | (chr[3:0] != r.lrc);
                    end
                end
                default: begin
                    next_r.phase = TRK_IDLE;
                    next_r.busy = 1'b0;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------
        if (wr_in && addr_in == TRK_REG_CTRL) begin
            next_r.edge_rise = wdata_in[TRK_CTRL_EDGE_RISE];
            next_r.invert = wdata_in[TRK_CTRL_INVERT];
            next_r.abort_en = wdata_in[TRK_CTRL_ABORT_EN];
            next_r.abort_sel = wdata_in[TRK_CTRL_ABORT_SEL_HI:TRK_CTRL_ABORT_SEL_LO];
            // Start is ignored mid-transfer so a stray write cannot restart a frame
            if (wdata_in[TRK_CTRL_START] && r.phase == TRK_IDLE) begin
                next_r.phase = TRK_HUNT;
                next_r.busy = 1'b1;
                next_r.done = 1'b0;
                next_r.err = 1'b0;
                next_r.framed = 1'b0;
                next_r.err_parity = 1'b0;
                next_r.err_lrc = 1'b0;
                next_r.err_overflow = 1'b0;
                next_r.err_abort = 1'b0;
                next_r.shreg = 5'h00;
                next_r.bitcnt = 3'h0;
                next_r.count = 6'h00;
                next_r.lrc = 4'h0;
                next_r.nib = '0;
            end
        end

        if (rd_in) begin
            if (addr_in == TRK_REG_CTRL) begin
                next_r.rdata[TRK_CTRL_EDGE_RISE] = r.edge_rise;
                next_r.rdata[TRK_CTRL_INVERT] = r.invert;
                next_r.rdata[TRK_CTRL_ABORT_EN] = r.abort_en;
                next_r.rdata[TRK_CTRL_ABORT_SEL_HI:TRK_CTRL_ABORT_SEL_LO] = r.abort_sel;
            end else if (addr_in == TRK_REG_STATUS) begin
                next_r.rdata[TRK_STAT_BUSY] = r.busy;
                next_r.rdata[TRK_STAT_DONE] = r.done;
                next_r.rdata[TRK_STAT_ERROR] = r.err;
                next_r.rdata[TRK_STAT_FRAMED] = r.framed;
                next_r.rdata[TRK_STAT_PARITY] = r.err_parity;
                next_r.rdata[TRK_STAT_LRC] = r.err_lrc;
                next_r.rdata[TRK_STAT_OVERFLOW] = r.err_overflow;
                next_r.rdata[TRK_STAT_ABORT] = r.err_abort;
                next_r.rdata[TRK_STAT_COUNT_HI:TRK_STAT_COUNT_LO] = r.count;
            end else if (addr_in == TRK_REG_RESULT) begin
                // Signed result: characters stored, or -1 on any failure
                next_r.rdata[7:0] = r.err ? TRK_RESULT_ERR : {2'h0, r.count};
            end else if (in_buffer(addr_in)) begin
                next_r.rdata[7:0] = buffer_byte(r.nib, addr_in);
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= TRK_STATE_RST;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_out = r.rdata;
    assign busy_out = r.busy;
    assign done_out = r.done;
    assign error_out = r.err;

endmodule : trk_reader

`default_nettype wire

// ===== trk_reader_checker.sv
// Port assertions for the track 2 stripe reader.
`timescale 1ns/100ps
`default_nettype none

module trk_reader_checker
    import trk_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [TRK_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic strobe_in,
    input wire logic data_in,
    input wire logic [TRK_NUM_ABORT-1:0] gpin_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic error_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    logic start_req;
    assign start_req = wr_in && addr_in == TRK_REG_CTRL && wdata_in[TRK_CTRL_START];

    chk_rd_quiet: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside read slot");
    chk_start_arm: assert property (start_req && !busy_out |=> busy_out && !done_out && !error_out)
        else $error("start did not arm the transfer");
    chk_busy_cause: assert property ($rose(busy_out) |-> $past(start_req))
        else $error("busy rose without a start");
    chk_err_done: assert property (error_out |-> done_out)
        else $error("error without done");
    chk_busy_excl: assert property (busy_out |-> !done_out)
        else $error("busy and done together");
    chk_done_sticky: assert property (done_out && !start_req |=> done_out)
        else $error("done dropped without a start");
    chk_err_sticky: assert property (error_out && !start_req |=> error_out)
        else $error("error dropped without a start");
    chk_done_cause: assert property ($rose(done_out) |-> $past(busy_out) && !busy_out)
        else $error("done rose outside a transfer");
    chk_result_err: assert property (rd_in && addr_in == TRK_REG_RESULT && error_out
        |=> rdata_out == {24'h0, TRK_RESULT_ERR})
        else $error("failed transfer result not minus one");
    chk_result_ok: assert property (rd_in && addr_in == TRK_REG_RESULT && done_out && !error_out
        |=> rdata_out[7:0] >= 8'h02 && rdata_out[7:0] <= TRK_MAX_COUNT)
        else $error("good transfer count out of range");

    cov_ok: cover property ($rose(done_out) && !error_out);
    cov_err: cover property ($rose(error_out));
    cov_rise: cover property (start_req && wdata_in[TRK_CTRL_EDGE_RISE]);
endmodule : trk_reader_checker

bind trk_reader trk_reader_checker chk_u (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .strobe_in, .data_in, .gpin_in, .busy_out, .done_out, .error_out);
`default_nettype wire

// ===== trk_card_model.sv
// Card reader model: strobe and data lines of a track 2 swipe.
`timescale 1ns/100ps
`default_nettype none

module trk_card_model (
    input wire logic rise_in,
    input wire logic inv_in,
    output logic strobe_out,
    output logic data_out
);
    logic last = 1'b0;

    // Strobe rests inactive; released data shows the inverse, never a stale bit
    task automatic idle();
        strobe_out = ~rise_in;
        data_out = ~last;
    endtask : idle

    // 160 ns bit cell, well inside the device's rate limit
    task automatic send_bit(input logic b);
        data_out = b ^ inv_in;
        last = data_out;
        #40 strobe_out = rise_in;
        #80 strobe_out = ~rise_in;
        #40 data_out = ~last;
    endtask : send_bit

    task automatic send_char(input logic [3:0] d, input logic bad);
        for (int i = 0; i < 4; i++) send_bit(d[i]);
        send_bit(~^d ^ bad);
    endtask : send_char
endmodule : trk_card_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the track 2 stripe reader.
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import trk_pkg::*;
;
    logic mclk, rst, wr, rd, rise, inv, strobe, data, busy, done, err, rd_seen;
    logic [7:0] addr, gpin;
    logic [31:0] wdata, rdata, seed;
    logic [31:0] exp_q[$];
    int failures, comparisons;

    trk_reader dut_u (.mclk_in(mclk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .strobe_in(strobe), .data_in(data), .gpin_in(gpin), .busy_out(busy),
        .done_out(done), .error_out(err));
    trk_card_model card_u (.rise_in(rise), .inv_in(inv), .strobe_out(strobe), .data_out(data));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rd_reg

    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) rd_seen <= rd;
    always @(negedge mclk) if (rd_seen === 1'b1) check(rdata, exp_q.pop_front());

    // Kind: 0 clean, 1 parity fault, 2 redundancy fault, 3 overflow, 4 abort
    task automatic run(input logic [7:0] ctrl, input int n, input int kind);
        logic [3:0] nib [0:40];
        logic [3:0] lrc;
        int last;
        lrc = TRK_START_CODE ^ TRK_END_CODE;
        nib[0] = TRK_START_CODE;
        for (int i = 1; i <= 40; i++) begin
            seed = xs(seed);
            nib[i] = (i <= n) ? 4'(seed[7:0] % 8'hA) : 4'h0;
            lrc ^= nib[i];
        end
        if (kind != 3) nib[n + 1] = TRK_END_CODE;
        last = (kind == 3) ? 40 : (kind == 1 || kind == 4) ? 2 : n + 1;
        rise = ctrl[TRK_CTRL_EDGE_RISE];
        inv = ctrl[TRK_CTRL_INVERT];
        card_u.idle();
        repeat (8) @(posedge mclk);
        gpin <= seed[7:0] & ~(8'h01 << ctrl[6:4]);
        wr_reg(TRK_REG_CTRL, {24'h0, ctrl | 8'h01});
        @(negedge mclk);
        check({31'h0, busy}, 32'h1);
        rd_reg(TRK_REG_CTRL, {24'h0, ctrl});
        for (int i = 0; i < 15; i++) card_u.send_bit(1'b0);
        for (int i = 0; i <= last; i++) card_u.send_char(nib[i], kind == 1 && i == 2);
        if (kind == 0 || kind == 2) card_u.send_char(lrc ^ 4'(kind == 2), 1'b0);
        if (kind == 4) begin
            @(posedge mclk);
            gpin <= gpin | (8'h01 << ctrl[6:4]);
            repeat (6000) @(posedge mclk);
            gpin <= 8'h00;
        end
        for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge mclk);
        @(negedge mclk);
        check({29'h0, busy, done, err}, {29'h0, 1'b0, 1'b1, kind != 0});
        rd_reg(TRK_REG_STATUS, 32'(((kind == 3) ? 40 : (kind == 1) ? 2 : (kind == 4) ? 3 : n + 2) << 8)
            | ((kind == 0) ? 32'hA : (32'hE | (32'h8 << kind))));
        rd_reg(TRK_REG_RESULT, (kind != 0) ? 32'hFF : 32'(n + 2));
        if (kind == 0) begin
            for (int i = 0; i < 20; i++) rd_reg(TRK_REG_BUF_BASE + 8'(4 * i),
                {24'h0, nib[2 * i], nib[2 * i + 1]});
        end
        $display("test kind %0d with %0d digits done", kind, n);
    endtask : run

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        {wr, rd, rise, inv} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        gpin = 8'h00;
        failures = 0;
        comparisons = 0;
        seed = 32'h77F5DC9A;
        card_u.idle();
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(TRK_REG_CTRL, 32'h0);
        rd_reg(TRK_REG_RESULT, 32'h0);
        wr_reg(TRK_REG_STATUS, 32'hFF);
        rd_reg(TRK_REG_STATUS, 32'h0);
        rd_reg(8'h41, 32'h0);
        rd_reg(8'h90, 32'h0);
        for (int m = 0; m < 4; m++) run(8'(m << 1), 2 + 4 * m, 0);
        run(8'h00, 38, 0);
        run(8'h00, 40, 3);
        run(8'h00, 5, 1);
        run(8'h00, 5, 2);
        run({1'b0, seed[2:0], 4'h8}, 3, 4);
        repeat (4) @(posedge mclk);
        report_and_stop();
    end

    // Hang guard, well beyond the expected run of about 200 us
    initial begin
        #900_000;
        failures++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
